// [hw/swc_cfg.svh]
// constants for the sleep and wake-up controller
// assumes a 125 MHz pclk and one-word apb registers at index * 4
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// ---------------------------------------------------------------
// register indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define STAT_IDX      16'h0003
`define PRESC_IDX     16'h0081
`define CFG_IDX       16'h2007
`define CTRL_IDX      16'h0010
`define FLAG_IDX      16'h0011
`define EVT_IDX       16'h0012
`define MASK_IDX      16'h0013

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define PWRDN_BIT     3
`define TO_BIT        4
`define PS_ASSIGN_BIT 3
`define PS_LSB        0
`define WDOG_EN_BIT   2
`define FOSC_LSB      0
`define FOSC_RC       2'h3
`define GLOBAL_EN_BIT 8
`define EV_SLEEP      0
`define EV_WAKE       1
`define EV_WDRST      2
`define PRESC_RST     8'h00
`define CFG_RST       8'h04
`define ISR_VECTOR    13'h0004

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PCLK_NS       8
`define OSC_PERIOD_NS 8
`define OST_PERIODS   1024
`define OST_CYCLES    ((`OST_PERIODS*`OSC_PERIOD_NS+`PCLK_NS-1)/`PCLK_NS)
`define WDOG_TIMEOUT_NS 18000000
`define WDOG_CYCLES   (`WDOG_TIMEOUT_NS/`PCLK_NS)

`endif

// [hw/swc_pkg.sv]
// types for the sleep and wake-up controller
// assumes swc_cfg.svh constants
package swc_pkg;

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OST   = 2'b10,
    ST_WAKE  = 2'b11
  } pstate_t;

  // ---------------------------------------------------------------
  // whole module state
  // ---------------------------------------------------------------
  typedef struct packed {
    pstate_t     st;
    logic [1:0]  sync;
    logic [31:0] wdog;
    logic [7:0]  post;
    logic [10:0] ost;
    logic        pwrdn;
    logic        to;
    logic [7:0]  flags;
    logic [7:0]  en;
    logic        global_irq_enable;
    logic [7:0]  presc;
    logic [2:0]  evt;
    logic [2:0]  emask;
    logic [7:0]  io_out;
    logic [7:0]  io_oe;
    logic [12:0] fetch;
    logic        resume;
    logic        vec;
    logic        nop;
    logic        dev_rst;
    logic [31:0] rdata;
  } swc_state_t;

endpackage : swc_pkg

// [hw/sleep_wakeup_control.sv]
// sleep and wake-up control: watchdog, power-down flags, wake
// sources, oscillator start-up wait and apb register slave
// assumes irq events and core strobes are on pclk; reset pin async
`include "swc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - sleep clears watchdog, keeps it running, clears power-down, sets to
// - io ports hold their pre-sleep drive state while asleep
// - wake on master clear, watchdog expiry if enabled, or interrupts
// - master clear fully resets; other wakes resume without reset
// - power-down flag set at power-up, cleared when sleep really executes
// - watchdog expiry ending sleep clears the to flag
// - only listed peripheral interrupts may wake the device
// - phase-clocked peripherals raise no interrupts while asleep
// - sleep prefetches the instruction at pc plus one
// - wake needs the source enable; global enable does not gate it
// - global enable clear: continue in line; set: then take vector
// - sleep with an enabled flag already pending acts as no-op
// - interrupt during sleep: instruction completes then wake at once
// - crystal modes wait 1024 osc periods on wake; rc mode none
// - expiry in run resets; expiry asleep only wakes
// - interrupt flags set on events regardless of enables
module sleep_wakeup_control
  import swc_pkg::*;
#(
  parameter logic [31:0] WDOG_CYCLES = `WDOG_CYCLES,
  parameter logic [7:0]  WAKE_MASK  = 8'hff,
  parameter logic [7:0]  CFG_WORD   = `CFG_RST
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_clear_pin_n,
  input  wire logic        sleep_instr,
  input  wire logic        kick_watchdog_instruction,
  input  wire logic [12:0] pc,
  input  wire logic [7:0]  irq_event,
  input  wire logic [7:0]  io_out_core,
  input  wire logic [7:0]  io_oe_core,
  output logic      [7:0]  io_out,
  output logic      [7:0]  io_oe,
  output logic             osc_enable,
  output logic             core_stall,
  output logic             core_resume,
  output logic             vector_req,
  output logic      [12:0] vector_addr,
  output logic      [12:0] prefetch_addr,
  output logic             sleep_nop,
  output logic             device_reset,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  swc_state_t q;
  swc_state_t d;

  logic [15:0] idx;
  logic        wr;
  logic        rd;
  logic        setup;
  logic        mapped;
  logic        wdog_en;
  logic        rc_mode;
  logic        tick;
  logic        expire;
  logic        clr_req;
  logic        pend;
  logic        wake_irq;
  logic [7:0]  ratio;
  logic [7:0]  fset;
  logic [7:0]  fclr;
  logic [2:0]  eset;
  logic [31:0] rval;

  assign idx     = {2'h0, paddr[15:2]};
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign wdog_en = CFG_WORD[`WDOG_EN_BIT];
  assign rc_mode = CFG_WORD[`FOSC_LSB +: 2] == `FOSC_RC;
  assign clr_req = !q.sync[1];
  assign ratio   = 8'h01 << q.presc[`PS_LSB +: 3];
  assign tick    = q.wdog == WDOG_CYCLES - 32'h1;

  // postscaler divides expiries only while assigned to the watchdog
  assign expire = wdog_en && tick
                  && (!q.presc[`PS_ASSIGN_BIT] || q.post == ratio - 8'h01);

  assign pend = |(q.flags & q.en);

  // wake needs the source enable and WAKE_MASK, not the global enable
  assign wake_irq = |(q.flags & q.en & WAKE_MASK);

  always_comb begin
    mapped = 1'b1;
    case (idx)
      `STAT_IDX:  rval = {27'h0, q.to, q.pwrdn, 3'h0};
      `PRESC_IDX: rval = {24'h0, q.presc};
      `CFG_IDX:   rval = {24'h0, CFG_WORD};
      `CTRL_IDX:  rval = {23'h0, q.global_irq_enable, q.en};
      `FLAG_IDX:  rval = {24'h0, q.flags};
      `EVT_IDX:   rval = {29'h0, q.evt};
      `MASK_IDX:  rval = {29'h0, q.emask};
      default: begin
        rval   = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d         = q;
    d.resume  = 1'b0;
    d.nop     = 1'b0;
    d.dev_rst = 1'b0;
    // two-flop synchroniser on the master clear pin
    d.sync    = {q.sync[0], master_clear_pin_n};
    eset      = 3'h0;
    fclr      = 8'h0;

    // watchdog runs through sleep on its own
    d.wdog = tick ? 32'h0 : q.wdog + 32'h1;
    if (tick) begin
      d.post = (q.post == ratio - 8'h01) ? 8'h00 : q.post + 8'h01;
    end
    if (kick_watchdog_instruction) begin
      d.wdog = 32'h0;
      d.post = 8'h00;
    end

    fset = irq_event & ((q.st == ST_RUN) ? 8'hff : WAKE_MASK);

    if (q.st == ST_RUN) begin
      d.io_out = io_out_core;
      d.io_oe  = io_oe_core;
    end

    case (q.st)
      ST_RUN: begin
        // resets take priority over a sleep in the same cycle
        if (clr_req || expire) begin
          d.dev_rst = 1'b1;
          d.to      = !expire;
          eset[`EV_WDRST] = expire;
        end else if (sleep_instr) begin
          d.fetch = pc + 13'h0001;
          if (pend) begin
            d.nop = 1'b1;
          end else begin
            // completes even if irq lands now
            d.st   = ST_SLEEP;
            d.pwrdn = 1'b0;
            d.to    = 1'b1;
            d.wdog  = 32'h0;
            d.post = 8'h00;
            eset[`EV_SLEEP] = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (clr_req) begin
          // master clear is a full reset
          d.st      = ST_RUN;
          d.dev_rst = 1'b1;
        end else if (expire || wake_irq) begin
          d.to  = q.to && !expire;
          d.st  = rc_mode ? ST_WAKE : ST_OST;
          d.ost = 11'h0;
          eset[`EV_WAKE] = 1'b1;
        end
      end
      ST_OST: begin
        // OST_CYCLES wait with osc_enable still low before the core resumes
        if (clr_req) begin
          d.st      = ST_RUN;
          d.dev_rst = 1'b1;
        end else if (q.ost == 11'(`OST_CYCLES - 1)) begin
          d.st = ST_WAKE;
        end else begin
          d.ost = q.ost + 11'h001;
        end
      end
      ST_WAKE: begin
        d.st     = ST_RUN;
        d.resume = 1'b1;
        d.vec    = q.global_irq_enable;
      end
      default: d.st = ST_RUN;
    endcase

    // apb writes and read side effects
    if (wr) begin
      case (idx)
        `PRESC_IDX: d.presc = pwdata[7:0];
        `CTRL_IDX: begin
          d.en  = pwdata[7:0];
          d.global_irq_enable = pwdata[`GLOBAL_EN_BIT];
        end
        `FLAG_IDX: fclr    = pwdata[7:0];
        `MASK_IDX: d.emask = pwdata[2:0];
        default: ;
      endcase
    end
    // read data latched in setup so a read-clear cannot race it
    if (setup) begin
      d.rdata = rval;
    end

    if (d.dev_rst) begin
      d.flags = 8'h0;
      d.en    = 8'h0;
      d.global_irq_enable   = 1'b0;
      d.presc = `PRESC_RST;
      d.wdog  = 32'h0;
      d.post  = 8'h00;
    end else begin
      // set wins over a clear in the same cycle
      d.flags = (q.flags & ~fclr) | fset;
    end
    d.evt = ((rd && idx == `EVT_IDX) ? 3'h0 : q.evt) | eset;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.st    <= ST_RUN;
      q.sync  <= 2'h3;
      // power-down and expiry flags set at power-up
      q.pwrdn <= 1'b1;
      q.to    <= 1'b1;
      q.presc <= `PRESC_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata        = q.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !mapped;
  assign io_out        = q.io_out;
  assign io_oe         = q.io_oe;
  assign osc_enable    = q.st == ST_RUN || q.st == ST_WAKE;
  assign core_stall    = q.st != ST_RUN;
  assign core_resume   = q.resume;
  assign vector_req    = q.vec && q.resume;
  assign vector_addr   = `ISR_VECTOR;
  assign prefetch_addr = q.fetch;
  assign sleep_nop     = q.nop;
  assign device_reset  = q.dev_rst;
  assign irq           = |(q.evt & q.emask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_sleep_entry: assert property (
    q.st == ST_RUN && sleep_instr && !pend && !clr_req && !expire
    |=> q.st == ST_SLEEP && !q.pwrdn && q.to && !osc_enable
        && q.wdog == 32'h0)
    else $error("sleep entry effects missing");

  chk_sleep_nop: assert property (
    q.st == ST_RUN && sleep_instr && pend && !clr_req && !expire
    |=> q.st == ST_RUN && sleep_nop && $stable(q.pwrdn) && $stable(q.to))
    else $error("pending irq sleep not a no-op");

  chk_io_hold: assert property (
    q.st != ST_RUN && $past(q.st) != ST_RUN
    |-> $stable(io_out) && $stable(io_oe))
    else $error("io moved while asleep");

  chk_wdt_wake: assert property (
    q.st == ST_SLEEP && expire && !clr_req
    |=> !q.to && q.st != ST_SLEEP && !device_reset)
    else $error("watchdog wake wrong");

  chk_wdt_reset: assert property (
    q.st == ST_RUN && expire |=> device_reset && !q.to)
    else $error("watchdog expiry in run did not reset");

  chk_master_clear_pin_reset: assert property (
    q.st == ST_SLEEP && clr_req |=> device_reset && q.st == ST_RUN)
    else $error("master clear did not reset");

  chk_irq_wake: assert property (
    q.st == ST_SLEEP && wake_irq && !clr_req
    |=> q.st == ST_OST || q.st == ST_WAKE)
    else $error("enabled irq did not wake");

  chk_ost_wait: assert property (
    $rose(q.st == ST_OST) |-> (q.st == ST_OST) [*8])
    else $error("start-up wait cut short");

  chk_resume_vec: assert property (
    q.st == ST_WAKE |=> core_resume && vector_req == $past(q.global_irq_enable))
    else $error("resume vectoring wrong");

  chk_prefetch: assert property (
    q.st == ST_RUN && sleep_instr && !clr_req && !expire
    |=> prefetch_addr == $past(pc) + 13'h0001)
    else $error("prefetch address wrong");

  chk_pwrdn_clear: assert property (
    $fell(q.pwrdn)
    |-> $past(sleep_instr) && $past(q.st) == ST_RUN && !$past(pend))
    else $error("power-down flag cleared without real sleep");

  chk_stay_asleep: assert property (
    q.st == ST_SLEEP && !clr_req && !expire && !wake_irq
    |=> q.st == ST_SLEEP)
    else $error("woke without a wake source");

  chk_quiet_sleep: assert property (
    q.st != ST_RUN
    |=> (q.flags & ~$past(q.flags) & ~WAKE_MASK) == 8'h00)
    else $error("non-wake source flagged while asleep");

  chk_late_irq: assert property (
    q.st == ST_RUN && sleep_instr && !pend && !clr_req && !expire && !wr
    && |(irq_event & q.en & WAKE_MASK)
    |=> q.st == ST_SLEEP ##1 q.st != ST_SLEEP)
    else $error("late irq did not complete sleep then wake");

  chk_ost_hold: assert property (
    q.st == ST_OST && !clr_req && q.ost != 11'(`OST_CYCLES - 1)
    |=> q.st == ST_OST)
    else $error("start-up wait left early");

  chk_nop_wdog: assert property (
    q.st == ST_RUN && sleep_instr && pend && !clr_req && !expire
    && !kick_watchdog_instruction && !tick
    |=> q.wdog == $past(q.wdog) + 32'h1)
    else $error("no-op sleep cleared the watchdog");

endmodule : sleep_wakeup_control

`default_nettype wire

// [sim/core_model.sv]
// core side model: program counter, free-running port drive,
// watchdog kicks and sleep or interrupt pulses on request
// assumes the controller's pclk domain and active-low presetn
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [7:0]  ev,
  input  wire logic        kick_en,
  input  wire logic        core_stall,
  output logic             sleep_instr,
  output logic             kick_watchdog_instruction,
  output logic      [12:0] pc,
  output logic      [7:0]  irq_event,
  output logic      [7:0]  port_drv
);
  logic go_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_d <= 1'b0;
      sleep_instr <= 1'b0;
      kick_watchdog_instruction <= 1'b0;
      pc <= 13'h0000;
      irq_event <= 8'h00;
      port_drv <= 8'h00;
    end else begin
      go_d <= go;
      sleep_instr <= go_d;
      kick_watchdog_instruction <= go |
        (kick_en & ~core_stall & (pc[8:0] == 9'h000));
      // pc and kick_en kicks pause while stalled; go kicks and sleep_instr are not gated by core_stall
      pc <= pc + {12'h000, ~core_stall};
      irq_event <= ev;
      // port drive keeps moving so a frozen output can be told apart
      port_drv <= port_drv + 8'h01;
    end
  end
endmodule : core_model
`default_nettype wire

// [sim/tb.sv]
// bench for the sleep and wake-up controller
// assumes core_model on the core side, apb byte address = index * 4
`include "swc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [31:0] PWRDN_M = 32'h1 << `PWRDN_BIT;
  localparam logic [31:0] TO_M = 32'h1 << `TO_BIT;
  logic        pclk = 1'b0, presetn = 1'b0, master_clear_pin_n = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, go = 1'b0, kick_en = 1'b1;
  logic [7:0]  ev = 8'h00, io_out, io_oe, irq_event, port_drv;
  logic        sleep_instr, kick_watchdog_instruction, osc_enable;
  logic        core_stall, core_resume, vector_req, sleep_nop;
  logic        device_reset, irq;
  logic [12:0] pc, pc_s, vector_addr, prefetch_addr;
  int          fails = 0, n_checks = 0, n_rst = 0, n, r;

  always #4 pclk = ~pclk;
  always @(posedge pclk) if (device_reset === 1'b1) n_rst++;

  sleep_wakeup_control #(.WDOG_CYCLES(32'd2000), .WAKE_MASK(8'h7f))
    sleep_wakeup_control_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .master_clear_pin_n, .sleep_instr,
    .kick_watchdog_instruction, .pc, .irq_event,
    .io_out_core(port_drv), .io_oe_core(~port_drv), .io_out, .io_oe,
    .osc_enable, .core_stall, .core_resume, .vector_req, .vector_addr,
    .prefetch_addr, .sleep_nop, .device_reset, .irq);

  core_model core_model_inst (.pclk, .presetn, .go, .ev, .kick_en,
    .core_stall, .sleep_instr, .kick_watchdog_instruction, .pc,
    .irq_event, .port_drv);

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task tmo;
    fails++;
    $display("[ERR] %0t wait timed out", $time);
    print_verdict;
  endtask : tmo
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 20) tmo;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input logic [15:0] idx, input logic [31:0] e, input string m);
    apb(1'b0, idx, 32'h0);
    chk(rd, e, m);
  endtask : rchk
  task poke(input logic g, input logic [7:0] e);
    @(posedge pclk);
    go <= g;
    ev <= e;
    @(posedge pclk);
    go <= 1'b0;
    ev <= 8'h00;
  endtask : poke
  task enter_sleep;
    poke(1'b1, 8'h00);
    for (int i = 0; i <= 10; i++) begin
      @(posedge pclk);
      if (sleep_instr === 1'b1) break;
      if (i == 10) tmo;
    end
    pc_s = pc;
    @(posedge pclk);
  endtask : enter_sleep
  task wait_resume;
    for (n = 1; n <= 4000; n++) begin
      @(posedge pclk);
      if (core_resume === 1'b1) break;
      if (n == 4000) tmo;
    end
  endtask : wait_resume

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task s_regs;
    rchk(`STAT_IDX, PWRDN_M | TO_M, "status after reset");
    rchk(`CFG_IDX, {24'h0, `CFG_RST}, "config word");
    apb(1'b1, `CFG_IDX, 32'hff);
    rchk(`CFG_IDX, {24'h0, `CFG_RST}, "config read-only");
    rchk(`PRESC_IDX, {24'h0, `PRESC_RST}, "prescaler reset");
    apb(1'b1, `PRESC_IDX, 32'h5);
    rchk(`PRESC_IDX, 32'h5, "prescaler write");
    rchk(16'h0040, 32'h0, "unmapped read");
    chk(err, 1, "unmapped error");
  endtask : s_regs
  task s_nop;
    apb(1'b1, `CTRL_IDX, 32'h001);
    poke(1'b0, 8'h01);
    enter_sleep;
    chk(sleep_nop, 1, "sleep as no-op");
    chk(core_stall, 0, "no stall on no-op");
    rchk(`STAT_IDX, PWRDN_M | TO_M, "flags kept");
    apb(1'b1, `FLAG_IDX, 32'h01);
  endtask : s_nop
  task s_wake(input logic g);
    logic [15:0] io_s;
    apb(1'b1, `CTRL_IDX, {23'h0, g, 8'h81});
    enter_sleep;
    io_s = {io_oe, io_out};
    chk(osc_enable, 0, "oscillator off");
    chk(prefetch_addr, pc_s + 13'h1, "prefetch");
    poke(1'b0, 8'h82);
    repeat (20) @(posedge pclk);
    chk(core_stall, 1, "disabled source woke");
    chk({io_oe, io_out}, io_s, "ports held");
    rchk(`STAT_IDX, TO_M, "status asleep");
    poke(1'b0, 8'h01);
    wait_resume;
    chk(n >= 1024 && n <= 1040, 1, "start-up wait");
    chk(vector_req, g, "vector request");
    chk(vector_addr, `ISR_VECTOR, "vector address");
    rchk(`FLAG_IDX, 32'h03, "flags");
    apb(1'b1, `FLAG_IDX, 32'h03);
  endtask : s_wake
  task s_irq;
    chk(irq, 0, "masked irq");
    apb(1'b1, `MASK_IDX, 32'h2);
    @(posedge pclk);
    chk(irq, 1, "wake irq");
    rchk(`EVT_IDX, 32'h3, "event status");
    @(posedge pclk);
    chk(irq, 0, "irq after read");
  endtask : s_irq
  task s_wdog_run;
    r = n_rst;
    @(posedge pclk);
    kick_en <= 1'b0;
    for (int i = 0; i <= 2200; i++) begin
      @(posedge pclk);
      if (n_rst != r) break;
      if (i == 2200) tmo;
    end
    kick_en <= 1'b1;
    rchk(`STAT_IDX, 32'h0, "expiry flag");
    rchk(`CTRL_IDX, 32'h0, "enables reset");
  endtask : s_wdog_run
  task s_wdog_sleep;
    enter_sleep;
    r = n_rst;
    rchk(`STAT_IDX, TO_M, "to set by sleep");
    wait_resume;
    chk(n_rst, r, "no reset on sleep expiry");
    rchk(`STAT_IDX, 32'h0, "wake cause");
  endtask : s_wdog_sleep
  task s_clr_pin;
    apb(1'b1, `CTRL_IDX, 32'h1ff);
    enter_sleep;
    r = n_rst;
    master_clear_pin_n <= 1'b0;
    @(posedge pclk);
    master_clear_pin_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(n_rst > r, 1, "master clear reset");
    chk(core_stall, 0, "running after clear");
    rchk(`CTRL_IDX, 32'h0, "enables cleared");
  endtask : s_clr_pin

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    s_regs;
    s_nop;
    s_wake(1'b0);
    s_irq;
    s_wdog_run;
    s_wdog_sleep;
    s_wake(1'b1);
    s_clr_pin;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
